// ### hw/add_logic_branch_exec.sv
/*
 Execution block for add, AND, AND-NOT and branch-if-zero instructions,
 with register file, carry flag, program counter and an AHB-Lite slave.
 Assumes instructions arrive from logic on CLK with a valid/ready pair,
 and a single AHB-Lite master doing single word transfers.
*/
// The AHB-Lite slave port and the register offsets were decided locally.
// Contract
// (RULE1) Register add writes rA plus rB to rD
// (RULE2) Bit 3 holds carry, else carry-out loads
// (RULE3) Bit 4 adds carry flag as carry-in
// (RULE4) Bits 3 and 4 select add variant
// (RULE5) Immediate add uses sign-extended immediate, same bits
// (RULE6) Immediate sign-extends unless prefix supplies upper half
// (RULE7) Register AND writes rA and rB
// (RULE8) Immediate AND uses sign-extended immediate
// (RULE9) Register AND-NOT writes rA and not rB
// (RULE10) Immediate AND-NOT inverts extended immediate
// (RULE11) Register branch: rA zero adds rB, else 4
// (RULE12) Immediate branch: rA zero adds immediate
// (RULE13) Opcode bit 6 marks delayed register branch
// (RULE14) Opcode bit 6 marks delayed immediate branch
// (RULE15) Delay slot completes before target when flagged
// (RULE16) Branch costs 1, 2 or 3 cycles
// (RULE17) Register form: opcode, rD, rA, rB
// (RULE18) Immediate form fields at 0, 6, 11, 16
// (RULE19) Add and logic complete in one cycle
// (RULE20) Carry-out is bit 32 of full sum
`timescale 1ns/10ps
module add_logic_branch_exec
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic [31:0] INSTR,
   input wire logic INSTR_VALID,
   output logic INSTR_READY,
   output logic [31:0] PC,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP
);
   logic [31:0] gpr_reg [0:exec_pkg::GPR_COUNT-1];
   logic [31:0] pc_reg;
   logic [31:0] target_reg;
   logic [31:0] hrdata_reg;
   logic [15:0] prefix_hi_reg;
   logic [11:0] addr_reg;
   logic carry_reg;
   logic run_reg;
   logic slot_reg;
   logic prefix_reg;
   logic wr_pend_reg;
   logic rd_wait_reg;
   exec_pkg::state_e state_reg;
   exec_pkg::state_e state_next;

   // Instruction decode
   wire [5:0] opc = INSTR[exec_pkg::OPC_HI:exec_pkg::OPC_LO]; // see (RULE17)
   wire [4:0] rd = INSTR[exec_pkg::RD_HI:exec_pkg::RD_LO]; // see (RULE18)
   wire [4:0] ra = INSTR[exec_pkg::RA_HI:exec_pkg::RA_LO];
   wire [4:0] rb = INSTR[exec_pkg::RB_HI:exec_pkg::RB_LO];
   wire [15:0] imm16 = INSTR[exec_pkg::IMM_HI:exec_pkg::IMM_LO];
   wire typeb = opc[exec_pkg::OPB_TYPEB];
   wire keep = opc[exec_pkg::OPB_KEEP];
   wire use_c = opc[exec_pkg::OPB_CARRY];
   wire dly = INSTR[exec_pkg::DELAY_BIT];
   wire [5:0] opc_reg_form = opc & ~exec_pkg::TYPEB_MASK;
   // see (RULE4)
   wire is_add = (opc[5:4] == exec_pkg::ADD_TOP) && !opc[0];
   wire is_and = (opc_reg_form == exec_pkg::AND_OPC);
   wire is_andn = (opc_reg_form == exec_pkg::ANDN_OPC);
   // see (RULE13) (RULE14)
   wire is_br = (opc_reg_form == exec_pkg::BR_REG_OPC) &&
      (INSTR[exec_pkg::COND_HI:exec_pkg::COND_LO] == exec_pkg::COND_EQ);
   wire is_prefix = (opc == exec_pkg::PREFIX_OPC);

   // Operands
   wire [31:0] ra_val = gpr_reg[ra];
   wire [31:0] rb_val = gpr_reg[rb];
   wire [31:0] sext_imm = {{16{imm16[15]}}, imm16};
   wire [31:0] imm_ext = prefix_reg ? {prefix_hi_reg, imm16} :
      sext_imm; // see (RULE6)
   wire [31:0] opnd_b = typeb ? imm_ext : rb_val; // see (RULE5)
   wire cin = use_c & carry_reg; // see (RULE3)
   wire [32:0] sum33 = {1'b0, ra_val} + {1'b0, opnd_b} +
      {32'h00000000, cin}; // see (RULE1) (RULE20)
   wire [31:0] and_res = ra_val & opnd_b; // see (RULE7) (RULE8)
   wire [31:0] andn_res = ra_val & ~opnd_b; // see (RULE9) (RULE10)
   wire [31:0] alu_res = is_add ? sum33[31:0] :
      (is_and ? and_res : andn_res);
   wire alu_wr = is_add | is_and | is_andn;

   // Branch resolution
   wire taken = is_br && (ra_val == 32'h00000000); // see (RULE11)
   wire [31:0] br_target = pc_reg + opnd_b; // see (RULE12)
   wire [31:0] pc_seq = pc_reg + exec_pkg::PC_STEP;

   // Handshake
   wire run_state = (state_reg == exec_pkg::ST_RUN);
   assign INSTR_READY = CE & run_reg & run_state & ~wr_pend_reg;
   wire fire = INSTR_VALID & INSTR_READY;

   // Next program counter
   wire [31:0] pc_exec = slot_reg ? target_reg :
      ((taken && !dly) ? br_target : pc_seq); // see (RULE15)

   // Stall sequencing after a taken branch
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         exec_pkg::ST_RUN:
         begin
            if (fire && taken && !slot_reg)
            begin
               // see (RULE16)
               state_next = dly ? exec_pkg::ST_WAIT1 : exec_pkg::ST_WAIT2;
            end
         end
         exec_pkg::ST_WAIT2:
         begin
            state_next = exec_pkg::ST_WAIT1;
         end
         exec_pkg::ST_WAIT1:
         begin
            state_next = exec_pkg::ST_RUN;
         end
         default:
         begin
            state_next = exec_pkg::ST_RUN;
         end
      endcase
   end

   // AHB-Lite decode
   wire addr_ph = HSEL & HTRANS[1] & HREADY & CE;
   wire gpr_hit = (addr_reg[11:7] == exec_pkg::GPR_BASE[11:7]);
   wire [4:0] gpr_idx = addr_reg[6:2];
   wire wr_ctrl = wr_pend_reg && (addr_reg == exec_pkg::CTRL_OFS);
   wire wr_msw = wr_pend_reg && (addr_reg == exec_pkg::MSW_OFS);
   wire wr_pc = wr_pend_reg && (addr_reg == exec_pkg::PC_OFS);
   wire wr_gpr = wr_pend_reg && gpr_hit;
   wire [31:0] status_word = {29'h00000000, prefix_reg, slot_reg,
      !run_state};
   wire [31:0] rd_mux =
      (addr_reg == exec_pkg::CTRL_OFS) ? {31'h00000000, run_reg} :
      (addr_reg == exec_pkg::MSW_OFS) ? {31'h00000000, carry_reg} :
      (addr_reg == exec_pkg::PC_OFS) ? pc_reg :
      (addr_reg == exec_pkg::STATUS_OFS) ? status_word :
      gpr_hit ? gpr_reg[gpr_idx] : 32'h00000000;
   assign HREADYOUT = CE & ~rd_wait_reg;
   assign HRESP = 1'b0;
   assign HRDATA = hrdata_reg;
   assign PC = pc_reg;

   // Bus slave state
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         addr_reg <= 12'h000;
         wr_pend_reg <= 1'b0;
         rd_wait_reg <= 1'b0;
         hrdata_reg <= 32'h00000000;
         run_reg <= exec_pkg::CTRL_RUN_RESET;
      end
      else if (CE)
      begin
         if (addr_ph)
         begin
            addr_reg <= {HADDR[11:2], 2'h0};
         end
         wr_pend_reg <= addr_ph & HWRITE;
         rd_wait_reg <= addr_ph & ~HWRITE;
         if (rd_wait_reg)
         begin
            hrdata_reg <= rd_mux;
         end
         if (wr_ctrl)
         begin
            run_reg <= HWDATA[exec_pkg::CTRL_RUN_BIT];
         end
      end
   end

   // Execution state
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         state_reg <= exec_pkg::ST_RUN;
         pc_reg <= exec_pkg::PC_RESET;
         target_reg <= exec_pkg::PC_RESET;
         carry_reg <= exec_pkg::CARRY_RESET;
         slot_reg <= 1'b0;
         prefix_reg <= 1'b0;
         prefix_hi_reg <= 16'h0000;
      end
      else if (CE)
      begin
         state_reg <= state_next;
         if (fire)
         begin
            pc_reg <= pc_exec;
            prefix_reg <= is_prefix;
            prefix_hi_reg <= imm16;
            slot_reg <= taken && dly && !slot_reg; // see (RULE15)
            target_reg <= br_target;
            if (is_add && !keep)
            begin
               carry_reg <= sum33[32]; // see (RULE2)
            end
         end
         else if (wr_pc)
         begin
            pc_reg <= HWDATA;
         end
         if (wr_msw)
         begin
            carry_reg <= HWDATA[exec_pkg::MSW_CARRY_BIT];
         end
      end
   end

   // Register file; bus writes never meet an accepted instruction
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         for (int i = 0; i < exec_pkg::GPR_COUNT; i++)
         begin
            gpr_reg[i] <= exec_pkg::GPR_RESET;
         end
      end
      else if (CE)
      begin
         if (fire && alu_wr)
         begin
            gpr_reg[rd] <= alu_res; // see (RULE19)
         end
         else if (wr_gpr)
         begin
            gpr_reg[gpr_idx] <= HWDATA;
         end
      end
   end

   // Checks
   wire chk_on = CE;
   wire alu_fire = fire & alu_wr;

   sequence s_wait_two;
      state_reg == exec_pkg::ST_WAIT2 ##1 state_reg == exec_pkg::ST_WAIT1
         ##1 state_reg == exec_pkg::ST_RUN;
   endsequence

   sequence s_wait_one;
      state_reg == exec_pkg::ST_WAIT1 ##1 state_reg == exec_pkg::ST_RUN;
   endsequence

   property p_add_result;
      @(posedge CLK) disable iff (RST || !chk_on)
      fire && is_add |=> gpr_reg[$past(rd)] == $past(sum33[31:0]);
   endproperty
   a_add_result: assert property (p_add_result) // see (RULE1)
      else $error("add result not written");

   property p_carry_keep;
      @(posedge CLK) disable iff (RST || !chk_on)
      fire && is_add && keep && !wr_msw |=> $stable(carry_reg);
   endproperty
   a_carry_keep: assert property (p_carry_keep) // see (RULE2)
      else $error("carry changed under keep");

   property p_carry_load;
      @(posedge CLK) disable iff (RST || !chk_on)
      fire && is_add && !keep |=> carry_reg == $past(sum33[32]);
   endproperty
   a_carry_load: assert property (p_carry_load) // see (RULE20)
      else $error("carry not loaded from carry-out");

   property p_no_cin;
      @(posedge CLK) disable iff (RST || !chk_on)
      fire && is_add && !use_c |=>
         gpr_reg[$past(rd)] == $past(ra_val) + $past(opnd_b);
   endproperty
   a_no_cin: assert property (p_no_cin) // see (RULE3)
      else $error("carry-in used without carry bit");

   property p_sext;
      @(posedge CLK) disable iff (RST || !chk_on)
      fire && typeb && !prefix_reg |->
         opnd_b == {{16{INSTR[15]}}, INSTR[15:0]};
   endproperty
   a_sext: assert property (p_sext) // see (RULE6)
      else $error("immediate not sign-extended");

   property p_andn;
      @(posedge CLK) disable iff (RST || !chk_on)
      fire && is_andn |=>
         gpr_reg[$past(rd)] == ($past(ra_val) & ~$past(opnd_b));
   endproperty
   a_andn: assert property (p_andn) // see (RULE9)
      else $error("and-not result wrong");

   property p_not_taken;
      @(posedge CLK) disable iff (RST || !chk_on)
      fire && is_br && !taken && !slot_reg |=>
         pc_reg == $past(pc_reg) + exec_pkg::PC_STEP && run_state;
   endproperty
   a_not_taken: assert property (p_not_taken) // see (RULE11)
      else $error("not-taken branch wrong");

   property p_taken_nodelay;
      @(posedge CLK) disable iff (RST || !chk_on)
      fire && taken && !dly && !slot_reg |=>
         pc_reg == $past(br_target) ##0 s_wait_two;
   endproperty
   a_taken_nodelay: assert property (p_taken_nodelay) // see (RULE16)
      else $error("taken branch without delay mistimed");

   property p_taken_delay;
      @(posedge CLK) disable iff (RST || !chk_on)
      fire && taken && dly && !slot_reg |=>
         slot_reg && pc_reg == $past(pc_seq) ##0 s_wait_one;
   endproperty
   a_taken_delay: assert property (p_taken_delay) // see (RULE15)
      else $error("delayed branch mistimed");

   property p_slot_target;
      @(posedge CLK) disable iff (RST || !chk_on)
      fire && slot_reg |=> pc_reg == $past(target_reg) && !slot_reg;
   endproperty
   a_slot_target: assert property (p_slot_target) // see (RULE15)
      else $error("target not taken after slot");

   property p_alu_single;
      @(posedge CLK) disable iff (RST || !chk_on)
      alu_fire && !slot_reg |=> run_state;
   endproperty
   a_alu_single: assert property (p_alu_single) // see (RULE19)
      else $error("stall after logic or add");
endmodule : add_logic_branch_exec

// ### hw/exec_pkg.sv
/*
 Constants for the add / logic / branch-if-zero execution block:
 instruction fields, opcodes, register map, reset values, taken-branch cycle counts.
 Assumes a 32-bit instruction word, field bit 0 being the word's MSB.
*/
package exec_pkg;
   // Instruction fields (vector bit = 31 - field bit)
   localparam int OPC_HI = 31;
   localparam int OPC_LO = 26;
   localparam int RD_HI = 25;
   localparam int RD_LO = 21;
   localparam int RA_HI = 20;
   localparam int RA_LO = 16;
   localparam int RB_HI = 15;
   localparam int RB_LO = 11;
   localparam int IMM_HI = 15;
   localparam int IMM_LO = 0;
   localparam int DELAY_BIT = 25;
   localparam int COND_HI = 24;
   localparam int COND_LO = 21;
   // Opcode bits inside the 6-bit opcode
   localparam int OPB_TYPEB = 3;
   localparam int OPB_KEEP = 2;
   localparam int OPB_CARRY = 1;
   localparam logic [1:0] ADD_TOP = 2'h0;
   localparam logic [5:0] BR_REG_OPC = 6'h27;
   localparam logic [3:0] COND_EQ = 4'h0;
   // Logical opcodes and prefix opcode: plain defaults
   localparam logic [5:0] AND_OPC = 6'h21;
   localparam logic [5:0] ANDN_OPC = 6'h23;
   localparam logic [5:0] PREFIX_OPC = 6'h2c;
   localparam logic [5:0] TYPEB_MASK = 6'h08;
   // Program counter
   localparam logic [31:0] PC_STEP = 32'h00000004;
   localparam logic [31:0] PC_RESET = 32'h00000000;
   // Register map, byte addresses
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] MSW_OFS = 12'h004;
   localparam logic [11:0] PC_OFS = 12'h008;
   localparam logic [11:0] STATUS_OFS = 12'h00c;
   localparam logic [11:0] GPR_BASE = 12'h080;
   localparam int CTRL_RUN_BIT = 0;
   localparam int MSW_CARRY_BIT = 0;
   localparam logic CTRL_RUN_RESET = 1'b1;
   localparam logic CARRY_RESET = 1'b0;
   localparam logic [31:0] GPR_RESET = 32'h00000000;
   localparam int GPR_COUNT = 32;
   // Taken-branch timing
   localparam int TAKEN_CYCLES_DELAY = 2;
   localparam int TAKEN_CYCLES_NODELAY = 3;

   typedef enum logic [1:0]
   {
      ST_RUN = 2'b00,
      ST_WAIT2 = 2'b01,
      ST_WAIT1 = 2'b10
   } state_e;
endpackage : exec_pkg

// ### sim/add_logic_branch_exec_bench.sv
/*
 Bench for add_logic_branch_exec: a model of registers, carry and PC
 is compared with the block; the PC after every instruction, the rest by bus reads.
 Assumes the bench is the only AHB-Lite master and the only source
 of instructions.
*/
`timescale 1ns/10ps
module add_logic_branch_exec_bench;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic [31:0] INSTR = 32'h0;
   logic INSTR_VALID = 1'b0;
   logic INSTR_READY;
   logic [31:0] PC;
   logic HSEL = 1'b0;
   logic [31:0] HADDR = 32'h0;
   logic [1:0] HTRANS = 2'h0;
   logic HWRITE = 1'b0;
   logic [31:0] HWDATA = 32'h0;
   logic [31:0] HRDATA;
   logic HREADYOUT;
   logic HRESP;
   logic CE = 1'b1;
   logic [31:0] m_gpr [32];
   logic [31:0] m_pc, m_tgt, q, hq;
   logic [15:0] m_ph, im;
   logic m_c, m_pv, m_pend;
   logic [4:0] rd, ra, rb;
   logic [5:0] op;
   int m_stall, err_total, check_count, k;
   localparam logic [5:0] ops [12] = '{6'h00, 6'h02, 6'h04, 6'h06,
      6'h08, 6'h0a, 6'h0c, 6'h0e, exec_pkg::AND_OPC, exec_pkg::ANDN_OPC,
      exec_pkg::AND_OPC | exec_pkg::TYPEB_MASK,
      exec_pkg::ANDN_OPC | exec_pkg::TYPEB_MASK};

   always #5 CLK = ~CLK;

   add_logic_branch_exec add_logic_branch_exec_i
   (
      .CLK(CLK), .RST(RST), .CE(CE), .INSTR(INSTR),
      .INSTR_VALID(INSTR_VALID), .INSTR_READY(INSTR_READY), .PC(PC),
      .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
      .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP)
   );

   task finish_test;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task tmo;
      err_total++;
      $display("unexpected handshake expected ready seen low");
      finish_test();
   endtask : tmo

   function automatic logic [31:0] mk(input logic [5:0] o,
      input logic [4:0] d, input logic [4:0] a, input logic [15:0] m);
      return {o, d, a, m};
   endfunction : mk

   function automatic logic [11:0] gaddr(input logic [4:0] r);
      return exec_pkg::GPR_BASE + {5'h0, r, 2'h0};
   endfunction : gaddr

   // Wait for hready at an edge, keeping the data seen there
   task hwait;
      int n;
      n = 0;
      @(negedge CLK);
      while (HREADYOUT !== 1'b1)
      begin
         n++;
         if (n > 50)
            tmo();
         @(negedge CLK);
      end
      hq = HRDATA;
      @(posedge CLK);
   endtask : hwait

   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HWRITE <= w;
      HADDR <= {20'h0, a};
      hwait();
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= d;
      hwait();
      q = hq;
   endtask : bus

   task rchk(input string nm, input logic [11:0] a, input logic [31:0] e,
      input logic [31:0] msk);
      bus(1'b0, a, 32'h0);
      chk(nm, e, q & msk);
   endtask : rchk

   task wgpr(input logic [4:0] i, input logic [31:0] v);
      bus(1'b1, gaddr(i), v);
      m_gpr[i] = v;
   endtask : wgpr

   task model(input logic [31:0] i);
      logic [5:0] o;
      logic [31:0] a, b, nx;
      logic [32:0] s;
      logic pend;
      o = i[31:26];
      a = m_gpr[i[20:16]];
      b = m_pv ? {m_ph, i[15:0]} : {{16{i[15]}}, i[15:0]};
      if (!o[3])
         b = m_gpr[i[15:11]];
      m_pv = 1'b0;
      pend = m_pend;
      m_pend = 1'b0;
      m_stall = 0;
      nx = m_pc + 32'h4;
      if (o[5:4] == 2'b00 && !o[0])
      begin
         s = {1'b0, a} + {1'b0, b} + {32'h0, o[1] & m_c};
         m_gpr[i[25:21]] = s[31:0];
         if (!o[2])
            m_c = s[32];
      end
      else if ((o | exec_pkg::TYPEB_MASK) == ops[10])
         m_gpr[i[25:21]] = a & b;
      else if ((o | exec_pkg::TYPEB_MASK) == ops[11])
         m_gpr[i[25:21]] = a & ~b;
      else if (o == exec_pkg::PREFIX_OPC)
      begin
         m_pv = 1'b1;
         m_ph = i[15:0];
      end
      else if ((o | 6'h08) == 6'h2f && i[24:21] == 4'h0 && a == 32'h0)
      begin
         m_stall = i[25] ? 1 : 2;
         m_pend = i[25];
         m_tgt = m_pc + b;
         if (!i[25])
            nx = m_tgt;
      end
      m_pc = pend ? m_tgt : nx;
   endtask : model

   task exec(input logic [31:0] i);
      int n;
      INSTR <= i;
      INSTR_VALID <= 1'b1;
      n = 0;
      @(negedge CLK);
      while (INSTR_READY !== 1'b1)
      begin
         n++;
         if (n > 50)
            tmo();
         @(negedge CLK);
      end
      @(posedge CLK);
      INSTR_VALID <= 1'b0;
      chk("stall", 32'(m_stall / 2), 32'(n));
      model(i);
      @(negedge CLK);
      chk("ready", {31'h0, m_stall == 0},
         {31'h0, INSTR_READY});
      chk("pc", m_pc, PC);
      @(posedge CLK);
   endtask : exec

   initial
   begin
      void'($urandom(63));
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      foreach (m_gpr[j])
         m_gpr[j] = 32'h0;
      m_pc = 32'h0;
      m_c = 1'b0;
      m_pv = 1'b0;
      m_pend = 1'b0;
      m_stall = 0;
      rchk("ctrl", exec_pkg::CTRL_OFS, 32'h1, 32'h1);
      rchk("msw", exec_pkg::MSW_OFS, 32'h0, 32'h1);
      rchk("gpr", gaddr(5'd9), 32'h0, 32'hffffffff);
      bus(1'b1, exec_pkg::STATUS_OFS, 32'h7);
      rchk("status", exec_pkg::STATUS_OFS, 32'h0, 32'h7);
      bus(1'b1, 12'h040, 32'hffffffff);
      rchk("unmapped", 12'h040, 32'h0, 32'hffffffff);
      for (k = 0; k < 36; k++)
      begin
         op = ops[k % 12];
         ra = 5'($urandom);
         rb = 5'($urandom);
         rd = 5'($urandom);
         wgpr(ra, $urandom);
         wgpr(rb, $urandom);
         m_c = 1'($urandom);
         bus(1'b1, exec_pkg::MSW_OFS, {31'h0, m_c});
         im = op[3] ? 16'($urandom) : {rb, 11'h0};
         exec(mk(op, rd, ra, im));
         rchk("result", gaddr(rd), m_gpr[rd],
            32'hffffffff);
         rchk("carry", exec_pkg::MSW_OFS, {31'h0, m_c},
            32'h1);
      end
      wgpr(5'd1, $urandom);
      exec(mk(exec_pkg::PREFIX_OPC, 5'd0, 5'd0, 16'h1234));
      rchk("status", exec_pkg::STATUS_OFS, 32'h4, 32'h7);
      exec(mk(6'h08, 5'd4, 5'd1, 16'h8001));
      rchk("prefixed", gaddr(5'd4), m_gpr[4], 32'hffffffff);
      exec(mk(6'h08, 5'd5, 5'd1, 16'h8001));
      rchk("extended", gaddr(5'd5), m_gpr[5], 32'hffffffff);
      for (k = 0; k < 8; k++)
      begin
         wgpr(5'd6, k[2] ? 32'h0 : ($urandom | 32'h1));
         wgpr(5'd7, 32'h40);
         bus(1'b1, exec_pkg::PC_OFS, 32'h100);
         m_pc = 32'h100;
         op = exec_pkg::BR_REG_OPC | (k[0] ? exec_pkg::TYPEB_MASK : 6'h0);
         im = k[0] ? 16'hffc0 : {5'd7, 11'h0};
         exec(mk(op, {k[1], 4'h0}, 5'd6, im));
         if (k[1])
            rchk("status", exec_pkg::STATUS_OFS, {30'h0, k[2], 1'h0},
               32'h7);
         exec(k[1] ? mk(6'h00, 5'd3, 5'd7, {5'd7, 11'h0}) :
            32'hfc000000);
         rchk("slot", gaddr(5'd3), m_gpr[3], 32'hffffffff);
      end
      // Clock enable low holds a pending stall and the bus
      wgpr(5'h06, 32'h0);
      bus(1'b1, exec_pkg::PC_OFS, 32'h100);
      m_pc = 32'h100;
      exec(mk(exec_pkg::BR_REG_OPC, 5'h00, 5'h06,
         {5'h07, 11'h0}));
      CE <= 1'b0;
      repeat (4) @(posedge CLK);
      @(negedge CLK);
      chk("frozen hready", 32'h0, {31'h0, HREADYOUT});
      chk("frozen pc", m_pc, PC);
      @(posedge CLK);
      CE <= 1'b1;
      exec(32'hfc000000);
      // Run bit low refuses instructions
      bus(1'b1, exec_pkg::CTRL_OFS, 32'h0);
      @(negedge CLK);
      chk("halted ready", 32'h0, {31'h0, INSTR_READY});
      @(posedge CLK);
      rchk("ctrl", exec_pkg::CTRL_OFS, 32'h0, 32'h1);
      bus(1'b1, exec_pkg::CTRL_OFS, 32'h1);
      exec(32'hfc000000);
      finish_test();
   end
endmodule : add_logic_branch_exec_bench
